// ---- verilog/mcu8_core.sv ----
// Summary of operation
// - conditional branch: 5 cycles taken, 4 not
// - seven ALU ops at 01-15, 4/6/7 cycles
// - compare at 16/17/18, 5/7/8 cycles
// - loads 19-1D with given cycles; 1E reserved
// - increment 21-24, decrement 25-28, 4/7/8 cycles
// - port read 29, write 2A, indexed 39
// - stores 31/32, exchanges 2F/30, given cycles
// - memory or/and/xor 33-38, 7/8 cycles
// - halt 00, no-op 20, page increment 1F
// - copies 40/41, stack load, interrupt enables, iret
// - jump 80-8F, calls 50-5F and 90-9F
// - branch ranges A0, B0, C0, D0
// - accumulator jump E0-EF, table lookup F0-FF
// - port read loads A; write sends A
// - indexed port address is constant plus X
// - reset clears registers; unlisted writes blocked
// - 256 bytes of data RAM
// - endpoint buffers at E8, F0, F8
// - push pre-decrements, pop post-increments
// - page increment advances upper six PC bits
// - call pushes two bytes, return pops two
`timescale 1ns/1ps
`default_nettype none
module mcu8_core
  import mcu8_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // program memory
  output logic      [PC_W-1:0]   prog_addr,
  input  wire logic [7:0]        prog_data,
  // port space
  output logic      [7:0]        io_addr,
  output logic      [7:0]        io_wdata,
  output logic                   io_wr,
  output logic                   io_rd,
  input  wire logic [7:0]        io_rdata,
  // endpoint buffer read port
  input  wire logic [1:0]        usb_ep,
  input  wire logic [2:0]        usb_idx,
  output logic      [7:0]        usb_rdata,
  // status
  output logic                   halted,
  output logic                   int_enable
);

  typedef struct packed {
    cpu_state_e      st;
    logic [3:0]      cnt;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] paddr;
    logic [7:0]      opc;
    logic [7:0]      opr;
    logic [7:0]      acc;
    logic [7:0]      idx;
    logic [7:0]      program_stack_pointer;
    logic [7:0]      dsp;
    logic [7:0]      stat;
    logic            cy;
    logic            zf;
    logic            ie;
    logic [7:0]      io_addr;
    logic [7:0]      io_wdata;
    logic            io_wr;
    logic            io_rd;
    logic [7:0]      usb_rdata;
  } core_s;

  core_s r;
  core_s n;

  logic [7:0] ram [RAM_DEPTH];
  logic       ram_we;
  logic [7:0] ram_wa;
  logic [7:0] ram_wd;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic br_taken(input logic [3:0] grp, input logic c, input logic z);
    case (grp)
      GRP_BR_Z:  br_taken = z;
      GRP_BR_NZ: br_taken = !z;
      GRP_BR_C:  br_taken = c;
      GRP_BR_NC: br_taken = !c;
      default:   br_taken = 1'b0;
    endcase
  endfunction

  function automatic logic two_byte(input logic [7:0] op);
    two_byte = (op >= OP_ALU_FIRST && op <= OP_LDX_DIR) ||
               (op >= OP_STA_DIR && op <= OP_PORT_WRX) ||
               op inside {8'(OP_INC_FIRST + 8'd2), 8'(OP_INC_FIRST + 8'd3),
                          8'(OP_DEC_FIRST + 8'd2), 8'(OP_DEC_FIRST + 8'd3),
                          OP_PORT_RD, OP_PORT_WR} ||
               op[7:4] inside {GRP_CALL_LO, GRP_JMP, GRP_CALL_HI, GRP_BR_Z, GRP_BR_NZ,
                               GRP_BR_C, GRP_BR_NC, GRP_ACC_JMP, GRP_TABLE};
  endfunction

  function automatic logic [3:0] op_cycles(input logic [7:0] op, input logic c,
                                           input logic z);
    logic [7:0] k;
    k = 8'((op - OP_ALU_FIRST) % 8'd3);
    op_cycles = CYC_SHORT;
    if (op >= OP_ALU_FIRST && op <= OP_ALU_LAST) begin
      op_cycles = (k == 8'd0) ? CYC_SHORT : (k == 8'd1) ? CYC_LONG : CYC_MEM;
    end else if (op >= OP_RMW_FIRST && op <= OP_RMW_LAST) begin
      op_cycles = op[0] ? CYC_MEM : CYC_MEM_IDX;
    end else begin
      case (op)
        OP_HALT:                 op_cycles = CYC_HALT;
        OP_CMP_IMM:              op_cycles = CYC_MID;
        OP_CMP_DIR:              op_cycles = CYC_MEM;
        OP_CMP_IDX:              op_cycles = CYC_MEM_IDX;
        OP_LDA_DIR, OP_LDX_DIR:  op_cycles = CYC_MID;
        OP_LDA_IDX:              op_cycles = CYC_LONG;
        8'(OP_INC_FIRST + 8'd2),
        8'(OP_DEC_FIRST + 8'd2): op_cycles = CYC_MEM;
        8'(OP_INC_FIRST + 8'd3),
        8'(OP_DEC_FIRST + 8'd3): op_cycles = CYC_MEM_IDX;
        OP_PORT_RD, OP_PORT_WR:  op_cycles = CYC_MID;
        OP_PORT_WRX:             op_cycles = CYC_LONG;
        OP_PUSH_A, OP_PUSH_X:    op_cycles = CYC_MID;
        OP_SWAP_AX, OP_SWAP_ADSP,
        OP_STA_DIR:              op_cycles = CYC_MID;
        OP_STA_IDX:              op_cycles = CYC_LONG;
        OP_SUB_RET, OP_INT_RET:  op_cycles = CYC_RETURN;
        default: begin
          case (op[7:4])
            GRP_CALL_LO, GRP_CALL_HI: op_cycles = CYC_CALL;
            GRP_JMP:                  op_cycles = CYC_JMP;
            GRP_BR_Z, GRP_BR_NZ, GRP_BR_C, GRP_BR_NC: begin
              op_cycles = br_taken(op[7:4], c, z) ? CYC_BR_TAKEN : CYC_BR_FALL;
            end
            GRP_ACC_JMP:              op_cycles = CYC_ACC_JMP;
            GRP_TABLE:                op_cycles = CYC_TABLE;
            default:                  op_cycles = CYC_SHORT;
          endcase
        end
      endcase
    end
  endfunction

  function automatic logic [8:0] alu(input logic [2:0] sel, input logic [7:0] a,
                                     input logic [7:0] b, input logic c);
    case (sel)  // carry out, or borrow for the subtracts
      3'd0:    alu = {1'b0, a} + {1'b0, b};
      3'd1:    alu = {1'b0, a} + {1'b0, b} + {8'h00, c};
      3'd2:    alu = {1'b0, a} - {1'b0, b};
      3'd3:    alu = {1'b0, a} - {1'b0, b} - {8'h00, c};
      3'd4:    alu = {c, a | b};
      3'd5:    alu = {c, a & b};
      default: alu = {c, a ^ b};
    endcase
  endfunction

  function automatic logic io_listed(input logic [7:0] a);
    case (a)
      IO_PORT0_PIN_DATA, IO_PORT1_PIN_DATA, IO_AUX_INPUT_LEVELS, IO_PORT0_IRQ_ENABLE,
      IO_PORT1_IRQ_ENABLE, IO_PORT0_IRQ_POLARITY, IO_PORT1_IRQ_POLARITY,
      IO_PORT0_DRIVE_CFG_A, IO_PORT0_DRIVE_CFG_B, IO_PORT1_DRIVE_CFG_A,
      IO_PORT1_DRIVE_CFG_B, IO_USB_DEVICE_ADDRESS, IO_ENDPOINT0_BYTE_COUNT,
      IO_ENDPOINT0_CONFIG, IO_ENDPOINT1_BYTE_COUNT, IO_ENDPOINT1_CONFIG,
      IO_ENDPOINT2_BYTE_COUNT, IO_ENDPOINT2_CONFIG, IO_USB_STATUS_CONTROL,
      IO_GLOBAL_IRQ_ENABLE, IO_ENDPOINT_IRQ_ENABLE, IO_FREE_TIMER_LOW, IO_FREE_TIMER_HIGH,
      IO_WATCHDOG_KICK, IO_CAPTURE_A_RISE, IO_CAPTURE_A_FALL, IO_CAPTURE_B_RISE,
      IO_CAPTURE_B_FALL, IO_CAPTURE_CONFIG, IO_CAPTURE_FLAGS, IO_SERIAL_SHIFT_DATA,
      IO_SERIAL_PORT_CONTROL, IO_OSCILLATOR_CONFIG: io_listed = 1'b1;
      default: io_listed = 1'b0;
    endcase
  endfunction

  // ****************************************
  // operand paths
  // ****************************************
  logic [7:0]      alu_k;
  logic [7:0]      rmw_k;
  logic [7:0]      inc_k;
  logic [7:0]      dec_k;
  logic            is_alu;
  logic            is_rmw;
  logic            is_idx;
  logic            is_imm;
  logic [7:0]      maddr;
  logic [7:0]      mval;
  logic [7:0]      opnd;
  logic [8:0]      alu_out;
  logic [7:0]      rmw_out;
  logic [7:0]      step_in;
  logic [8:0]      step_out;
  logic [PC_W-1:0] pc_step;
  logic [PC_W-1:0] jtgt;
  logic [7:0]      port_addr;
  logic [7:0]      stk_first;
  logic [7:0]      stk_second;
  logic [7:0]      usb_base;

  assign alu_k   = r.opc - OP_ALU_FIRST;
  assign rmw_k   = r.opc - OP_RMW_FIRST;
  assign inc_k   = r.opc - OP_INC_FIRST;
  assign dec_k   = r.opc - OP_DEC_FIRST;
  assign is_alu  = r.opc >= OP_ALU_FIRST && r.opc <= OP_ALU_LAST;
  assign is_rmw  = r.opc >= OP_RMW_FIRST && r.opc <= OP_RMW_LAST;
  assign is_imm  = (is_alu && alu_k % 8'd3 == 8'd0) ||
                   r.opc inside {OP_CMP_IMM, OP_LDA_IMM, OP_LDX_IMM};
  assign is_idx  = (is_alu && alu_k % 8'd3 == 8'd2) || (is_rmw && rmw_k[0]) ||
                   r.opc inside {OP_CMP_IDX, OP_LDA_IDX, OP_STA_IDX, OP_PORT_WRX,
                                 8'(OP_INC_FIRST + 8'd3), 8'(OP_DEC_FIRST + 8'd3)};
  assign maddr   = is_idx ? 8'(r.opr + r.idx) : r.opr;
  assign mval    = ram[maddr];
  assign opnd    = is_imm ? r.opr : mval;
  assign alu_out = alu(is_alu ? 3'(alu_k / 8'd3) : ALU_SUB, r.acc, opnd, r.cy);
  assign rmw_out = (rmw_k[2:1] == 2'd0) ? (mval | r.acc) :
                   (rmw_k[2:1] == 2'd1) ? (mval & r.acc) : (mval ^ r.acc);
  // lower byte wraps inside its page
  assign pc_step = {r.pc[PC_W-1:8], 8'(r.pc[7:0] + 8'd1)};
  assign jtgt    = {r.pc[PC_W-1:12], r.opc[3:0], r.opr};
  assign port_addr = (r.opc == OP_PORT_WRX) ? 8'(r.opr + r.idx) : r.opr;
  assign stk_first  = ram[8'(r.program_stack_pointer - 8'd2)];
  assign stk_second = ram[8'(r.program_stack_pointer - 8'd1)];

  always_comb begin
    step_in = mval;
    if (inc_k == 8'd0 || dec_k == 8'd0) begin
      step_in = r.acc;
    end else if (inc_k == 8'd1 || dec_k == 8'd1) begin
      step_in = r.idx;
    end
  end
  assign step_out = (inc_k < 8'd4) ? {1'b0, step_in} + 9'd1 : {1'b0, step_in} - 9'd1;

  always_comb begin
    case (usb_ep)
      2'd1:    usb_base = EP1_BUF_BASE;
      2'd2:    usb_base = EP2_BUF_BASE;
      default: usb_base = EP0_BUF_BASE;
    endcase
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    n = r;
    ram_we = 1'b0;
    ram_wa = 8'h00;
    ram_wd = 8'h00;
    n.io_wr = 1'b0;
    n.io_rd = 1'b0;
    n.usb_rdata = ram[8'(usb_base + {5'b00000, usb_idx})];
    case (r.st)
      S_OPC: begin
        n.opc   = prog_data;
        n.pc    = pc_step;
        n.paddr = pc_step;
        n.cnt   = 4'(op_cycles(prog_data, r.cy, r.zf) - 4'd1);
        n.st    = two_byte(prog_data) ? S_OPR : S_WAIT;
      end
      S_OPR: begin
        n.opr   = prog_data;
        n.pc    = pc_step;
        n.paddr = pc_step;
        n.cnt   = 4'(r.cnt - 4'd1);
        n.st    = S_WAIT;
      end
      S_WAIT: begin
        if (r.cnt != 4'd1) begin
          n.cnt = 4'(r.cnt - 4'd1);
          if (r.cnt == 4'd2) begin
            // writes to reserved addresses and the internal status byte never strobe out (port reads always do),
            // and the bus keeps its last address and data for them
            if (r.opc inside {OP_PORT_RD, OP_PORT_WR, OP_PORT_WRX} &&
                (r.opc == OP_PORT_RD || io_listed(port_addr))) begin
              n.io_addr  = port_addr;
              n.io_wdata = r.acc;
              n.io_rd    = r.opc == OP_PORT_RD;
              n.io_wr    = r.opc != OP_PORT_RD;
            end
            if (r.opc[7:4] inside {GRP_CALL_LO, GRP_CALL_HI}) begin
              ram_we = 1'b1;
              ram_wa = r.program_stack_pointer;
              ram_wd = {r.cy, r.zf, r.pc[PC_W-1:8]};
            end
            if (r.opc[7:4] == GRP_TABLE) begin
              n.paddr = PC_W'({r.pc[PC_W-1:12], r.opc[3:0], r.opr} + {6'h00, r.acc});
            end
          end
        end else begin
          n.st = S_OPC;
          if (r.opc == OP_HALT) begin
            n.st = S_HALT;
          end else if (is_alu) begin
            n.acc = alu_out[7:0];
            n.cy  = alu_out[8];
            n.zf  = alu_out[7:0] == 8'h00;
          end else if (is_rmw) begin
            ram_we = 1'b1;
            ram_wa = maddr;
            ram_wd = rmw_out;
            n.zf   = rmw_out == 8'h00;
          end else if (inc_k < 8'd4 || dec_k < 8'd4) begin
            n.cy = step_out[8];
            n.zf = step_out[7:0] == 8'h00;
            if (inc_k == 8'd0 || dec_k == 8'd0) begin
              n.acc = step_out[7:0];
            end else if (inc_k == 8'd1 || dec_k == 8'd1) begin
              n.idx = step_out[7:0];
            end else begin
              ram_we = 1'b1;
              ram_wa = maddr;
              ram_wd = step_out[7:0];
            end
          end else begin
            case (r.opc)
              OP_CMP_IMM, OP_CMP_DIR, OP_CMP_IDX: begin
                n.cy = alu_out[8];
                n.zf = alu_out[7:0] == 8'h00;
              end
              OP_LDA_IMM, OP_LDA_DIR, OP_LDA_IDX: n.acc = opnd;
              OP_LDX_IMM, OP_LDX_DIR:             n.idx = opnd;
              OP_RESERVED, OP_NOP:                ;
              OP_PAGE_INC: n.pc = {6'(r.pc[PC_W-1:8] + 6'd1), r.pc[7:0]};
              OP_PORT_RD: begin
                n.acc = (port_addr == IO_CPU_STATUS_CONTROL) ? r.stat : io_rdata;
              end
              OP_PORT_WR, OP_PORT_WRX: begin
                if (port_addr == IO_CPU_STATUS_CONTROL) begin
                  n.stat = r.acc;
                end
              end
              OP_POP_A, OP_POP_X: begin
                if (r.opc == OP_POP_A) begin
                  n.acc = ram[r.dsp];
                end else begin
                  n.idx = ram[r.dsp];
                end
                n.dsp = 8'(r.dsp + 8'd1);
              end
              OP_PUSH_A, OP_PUSH_X: begin
                n.dsp  = 8'(r.dsp - 8'd1);
                ram_we = 1'b1;
                ram_wa = 8'(r.dsp - 8'd1);
                ram_wd = (r.opc == OP_PUSH_A) ? r.acc : r.idx;
              end
              OP_SWAP_AX: begin
                n.acc = r.idx;
                n.idx = r.acc;
              end
              OP_SWAP_ADSP: begin
                n.acc = r.dsp;
                n.dsp = r.acc;
              end
              OP_STA_DIR, OP_STA_IDX: begin
                ram_we = 1'b1;
                ram_wa = maddr;
                ram_wd = r.acc;
              end
              OP_CPL: n.acc = ~r.acc;
              OP_SHL: {n.cy, n.acc} = {r.acc, 1'b0};
              OP_ASR: {n.acc, n.cy} = {r.acc[7], r.acc};
              OP_RLC: {n.cy, n.acc} = {r.acc, r.cy};
              OP_RRC: {n.acc, n.cy} = {r.cy, r.acc};
              OP_SUB_RET, OP_INT_RET: begin
                n.pc  = {stk_first[5:0], stk_second};
                n.program_stack_pointer = 8'(r.program_stack_pointer - 8'd2);
                if (r.opc == OP_INT_RET) begin
                  {n.cy, n.zf} = stk_first[7:6];
                  n.ie = 1'b1;
                end
              end
              OP_MOV_AX:   n.acc = r.idx;
              OP_MOV_XA:   n.idx = r.acc;
              OP_PSP_LOAD: n.program_stack_pointer = r.acc;
              OP_INT_DIS:  n.ie  = 1'b0;
              OP_INT_EN:   n.ie  = 1'b1;
              default: begin
                case (r.opc[7:4])
                  GRP_CALL_LO, GRP_CALL_HI: begin
                    ram_we = 1'b1;
                    ram_wa = 8'(r.program_stack_pointer + 8'd1);
                    ram_wd = r.pc[7:0];
                    n.program_stack_pointer  = 8'(r.program_stack_pointer + 8'd2);
                    // low group reaches the first 4K, high group the second
                    n.pc   = {1'b0, r.opc[7], r.opc[3:0], r.opr};
                  end
                  GRP_JMP: n.pc = jtgt;
                  GRP_BR_Z, GRP_BR_NZ, GRP_BR_C, GRP_BR_NC: begin
                    if (br_taken(r.opc[7:4], r.cy, r.zf)) begin
                      n.pc = jtgt;
                    end
                  end
                  GRP_ACC_JMP: n.pc = PC_W'(jtgt + {6'h00, r.acc});
                  GRP_TABLE:   n.acc = prog_data;
                  default: ;
                endcase
              end
            endcase
          end
          n.paddr = n.pc;
        end
      end
      S_HALT: n.st = S_HALT;
      default: n.st = S_OPC;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r      <= '0;
      r.stat <= CPU_STATUS_RESET;
    end else begin
      r <= n;
    end
  end

  // data RAM carries no reset
  always_ff @(posedge core_clk) begin
    if (ram_we) begin
      ram[ram_wa] <= ram_wd;
    end
  end

  assign prog_addr  = r.paddr;
  assign io_addr    = r.io_addr;
  assign io_wdata   = r.io_wdata;
  assign io_wr      = r.io_wr;
  assign io_rd      = r.io_rd;
  assign usb_rdata  = r.usb_rdata;
  assign halted     = r.st == S_HALT;
  assign int_enable = r.ie;

endmodule
`default_nettype wire

// ---- verilog/mcu8_pkg.sv ----
package mcu8_pkg;

  // ****************************************
  // widths and memory
  // ****************************************
  localparam int PC_W      = 14;
  localparam int RAM_DEPTH = 256;
  localparam logic [7:0] EP2_BUF_BASE = 8'hE8;
  localparam logic [7:0] EP1_BUF_BASE = 8'hF0;
  localparam logic [7:0] EP0_BUF_BASE = 8'hF8;

  // ****************************************
  // port-space register map
  // ****************************************
  localparam logic [7:0] IO_PORT0_PIN_DATA = 8'h00, IO_PORT1_PIN_DATA = 8'h01,
    IO_AUX_INPUT_LEVELS = 8'h02, IO_PORT0_IRQ_ENABLE = 8'h04, IO_PORT1_IRQ_ENABLE = 8'h05,
    IO_PORT0_IRQ_POLARITY = 8'h06, IO_PORT1_IRQ_POLARITY = 8'h07,
    IO_PORT0_DRIVE_CFG_A = 8'h0A, IO_PORT0_DRIVE_CFG_B = 8'h0B,
    IO_PORT1_DRIVE_CFG_A = 8'h0C, IO_PORT1_DRIVE_CFG_B = 8'h0D,
    IO_USB_DEVICE_ADDRESS = 8'h10, IO_ENDPOINT0_BYTE_COUNT = 8'h11,
    IO_ENDPOINT0_CONFIG = 8'h12, IO_ENDPOINT1_BYTE_COUNT = 8'h13,
    IO_ENDPOINT1_CONFIG = 8'h14, IO_ENDPOINT2_BYTE_COUNT = 8'h15,
    IO_ENDPOINT2_CONFIG = 8'h16, IO_USB_STATUS_CONTROL = 8'h1F,
    IO_GLOBAL_IRQ_ENABLE = 8'h20, IO_ENDPOINT_IRQ_ENABLE = 8'h21,
    IO_FREE_TIMER_LOW = 8'h24, IO_FREE_TIMER_HIGH = 8'h25, IO_WATCHDOG_KICK = 8'h26,
    IO_CAPTURE_A_RISE = 8'h40, IO_CAPTURE_A_FALL = 8'h41, IO_CAPTURE_B_RISE = 8'h42,
    IO_CAPTURE_B_FALL = 8'h43, IO_CAPTURE_CONFIG = 8'h44, IO_CAPTURE_FLAGS = 8'h45,
    IO_SERIAL_SHIFT_DATA = 8'h60, IO_SERIAL_PORT_CONTROL = 8'h61,
    IO_OSCILLATOR_CONFIG = 8'hF8, IO_CPU_STATUS_CONTROL = 8'hFF;
  localparam logic [7:0] CPU_STATUS_RESET = 8'h00;

  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OP_HALT = 8'h00, OP_ALU_FIRST = 8'h01, OP_ALU_LAST = 8'h15,
    OP_CMP_IMM = 8'h16, OP_CMP_DIR = 8'h17, OP_CMP_IDX = 8'h18,
    OP_LDA_IMM = 8'h19, OP_LDA_DIR = 8'h1A, OP_LDA_IDX = 8'h1B,
    OP_LDX_IMM = 8'h1C, OP_LDX_DIR = 8'h1D, OP_RESERVED = 8'h1E,
    OP_PAGE_INC = 8'h1F, OP_NOP = 8'h20, OP_INC_FIRST = 8'h21, OP_DEC_FIRST = 8'h25,
    OP_PORT_RD = 8'h29, OP_PORT_WR = 8'h2A, OP_POP_A = 8'h2B, OP_POP_X = 8'h2C,
    OP_PUSH_A = 8'h2D, OP_PUSH_X = 8'h2E, OP_SWAP_AX = 8'h2F, OP_SWAP_ADSP = 8'h30,
    OP_STA_DIR = 8'h31, OP_STA_IDX = 8'h32, OP_RMW_FIRST = 8'h33, OP_RMW_LAST = 8'h38,
    OP_PORT_WRX = 8'h39, OP_CPL = 8'h3A, OP_SHL = 8'h3B, OP_ASR = 8'h3C,
    OP_RLC = 8'h3D, OP_RRC = 8'h3E, OP_SUB_RET = 8'h3F, OP_MOV_AX = 8'h40,
    OP_MOV_XA = 8'h41, OP_PSP_LOAD = 8'h60, OP_INT_DIS = 8'h70, OP_INT_EN = 8'h72,
    OP_INT_RET = 8'h73;
  localparam logic [3:0] GRP_CALL_LO = 4'h5, GRP_JMP = 4'h8, GRP_CALL_HI = 4'h9,
    GRP_BR_Z = 4'hA, GRP_BR_NZ = 4'hB, GRP_BR_C = 4'hC, GRP_BR_NC = 4'hD,
    GRP_ACC_JMP = 4'hE, GRP_TABLE = 4'hF;
  localparam logic [2:0] ALU_SUB = 3'd2;

  // ****************************************
  // cycle counts
  // ****************************************
  localparam logic [3:0] CYC_SHORT = 4'd4, CYC_MID = 4'd5, CYC_LONG = 4'd6,
    CYC_MEM = 4'd7, CYC_MEM_IDX = 4'd8, CYC_HALT = 4'd7, CYC_CALL = 4'd10,
    CYC_TABLE = 4'd14, CYC_BR_TAKEN = 4'd5, CYC_BR_FALL = 4'd4, CYC_JMP = 4'd5,
    CYC_ACC_JMP = 4'd7, CYC_RETURN = 4'd8;

  typedef enum logic [1:0] {
    S_OPC  = 2'b00,
    S_OPR  = 2'b01,
    S_WAIT = 2'b11,
    S_HALT = 2'b10
  } cpu_state_e;

endpackage

// ---- verification/mcu8_core_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcu8_core_chk
  import mcu8_pkg::*;
(
  // clock and reset
  input wire logic            core_clk,
  input wire logic            reset_n,
  // watched outputs
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic [7:0]      io_addr,
  input wire logic [7:0]      io_wdata,
  input wire logic            io_wr,
  input wire logic            io_rd,
  input wire logic            halted
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_strobe; io_wr || io_rd; endsequence
  sequence s_quiet; !(io_wr || io_rd) [*4]; endsequence
  a_strobe_gap: assert property (s_strobe |=> s_quiet)
    else $error("port strobes too close");
  a_wr_pulse: assert property (io_wr |=> !io_wr) else $error("write strobe too long");
  a_rd_pulse: assert property (io_rd |=> !io_rd) else $error("read strobe too long");
  a_wr_rd_apart: assert property (!(io_wr && io_rd)) else $error("read and write at once");
  a_wr_mapped: assert property (io_wr |-> io_addr inside {[8'h00:8'h02], [8'h04:8'h07],
    [8'h0A:8'h0D], [8'h10:8'h16], [8'h1F:8'h21], [8'h24:8'h26], [8'h40:8'h45],
    [8'h60:8'h61], 8'hF8}) else $error("write strobe on unlisted address");
  a_halt_sticky: assert property (halted |=> halted) else $error("halt left early");
  a_halt_silent: assert property (halted |-> !io_wr && !io_rd)
    else $error("port strobe while halted");
  a_halt_nofetch: assert property (halted |=> $stable(prog_addr))
    else $error("fetch while halted");
  a_addr_hold: assert property ($changed(io_addr) |-> io_wr || io_rd)
    else $error("port address moved without strobe");
  a_wdata_hold: assert property ($changed(io_wdata) |-> io_wr || io_rd)
    else $error("port data moved without strobe");
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
  import mcu8_pkg::*;
  logic            core_clk, reset_n, io_wr, io_rd, halted, int_enable;
  logic [PC_W-1:0] prog_addr;
  logic [7:0]      prog_data, io_addr, io_wdata, io_rdata, usb_rdata, r, x, q;
  logic [1:0]      usb_ep;
  logic [2:0]      usb_idx;
  logic [7:0]      rom [0:255];
  logic [7:0]      prg [21];
  int              failures, samples_checked, seed, cyc, nx;
  int              wr_t[$];
  logic [15:0]     wr_q[$];
  // {opcode, length, cycles}; 1F and returns left out, they leave page 0
  logic [15:0] tbl [53] = '{16'h0124, 16'h0226, 16'h0327, 16'h0424, 16'h0724, 16'h0A24,
    16'h0D24, 16'h1024, 16'h1324, 16'h1625, 16'h1727, 16'h1828, 16'h1924, 16'h1A25, 16'h1B26,
    16'h1C24, 16'h1D25, 16'h1E14, 16'h2014, 16'h2114, 16'h2327, 16'h2428, 16'h2614, 16'h2727,
    16'h2828, 16'h2925, 16'h2B14, 16'h2D15, 16'h2F15, 16'h3015, 16'h3125, 16'h3226, 16'h3327,
    16'h3828, 16'h3926, 16'h3A14, 16'h3B14, 16'h3C14, 16'h3D14, 16'h3E14, 16'h4014, 16'h4114,
    16'h6014, 16'h7014, 16'h7214, 16'h502A, 16'h8025, 16'hA024, 16'hB025, 16'hC024, 16'hD025,
    16'hE027, 16'hF02E};
  assign prog_data = rom[prog_addr[7:0]];
  mcu8_core DUT (.core_clk(core_clk), .reset_n(reset_n), .prog_addr(prog_addr),
    .prog_data(prog_data), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_rdata(io_rdata), .usb_ep(usb_ep), .usb_idx(usb_idx), .usb_rdata(usb_rdata),
    .halted(halted), .int_enable(int_enable));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (io_wr === 1'b1) begin
      wr_t.push_back(cyc);
      wr_q.push_back({io_addr, io_wdata});
    end
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic run_prog();
    int n;
    reset_n = 1'b0;
    wr_t.delete();
    wr_q.delete();
    repeat (5) @(negedge core_clk);
    `CHK("reset halted", 1'b0, halted)
    reset_n = 1'b1;
    n = 0;
    while (halted !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 400) begin
      failures++;
      summarize();
    end
  endtask
  initial begin
    reset_n = 1'b0;
    io_rdata = 8'h00;
    usb_ep = 2'd0;
    usb_idx = 3'd0;
    seed = 30;
    // timing: interval between two bracketing writes is cycles plus the write's five
    foreach (tbl[i]) begin
      // programs stay low in page 0, clear of the reserved top
      foreach (rom[k]) rom[k] = 8'h00;
      rom[0] = 8'h2A; rom[1] = 8'h10; rom[2] = tbl[i][15:8]; rom[3] = 8'h04;
      nx = 2 + int'(tbl[i][7:4]);
      rom[nx] = 8'h2A;
      rom[nx+1] = 8'h11;
      run_prog();
      `CHK("writes", 2 + (tbl[i][15:8] == OP_PORT_WRX), wr_t.size())
      `CHK("cycles", int'(tbl[i][3:0]) + 5, wr_t[$] - wr_t[0])
      `CHK("int flag", tbl[i][15:8] == OP_INT_EN, int_enable)
    end
    // port data path, indexed address, unlisted write, endpoint buffer
    r = 8'($random(seed));
    x = 8'($random(seed) & 3);
    q = 8'($random(seed));
    io_rdata = q;
    prg = '{8'h19, r, 8'h31, 8'hEB, 8'h2A, 8'h10, 8'h29, 8'hFF, 8'h2A, 8'h11, 8'h1C, x,
      8'h39, 8'h10, 8'h2A, 8'h03, 8'h29, 8'h20, 8'h2A, 8'h12, 8'h00};
    foreach (prg[k]) rom[k] = prg[k];
    run_prog();
    `CHK("write count", 4, wr_q.size())
    if (wr_q.size() == 4) begin
      `CHK("write a", {8'h10, r}, wr_q[0])
      `CHK("status reset", 16'h1100, wr_q[1])
      `CHK("indexed write", {8'h10 + x, 8'h00}, wr_q[2])
      `CHK("read to write", {8'h12, q}, wr_q[3])
    end
    usb_ep = 2'd2;
    usb_idx = 3'd3;
    repeat (2) @(negedge core_clk);
    `CHK("endpoint byte", r, usb_rdata)
    // stack round trip through a call; only listed ports are written
    foreach (rom[k]) rom[k] = 8'h00;
    prg = '{8'h19, r, 8'h2D, 8'h19, 8'h00, 8'h2B, 8'h50, 8'h10, 8'h2A, 8'h11, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h21, 8'h2A, 8'h10, 8'h3F, 8'h00};
    foreach (prg[k]) rom[k] = prg[k];
    run_prog();
    `CHK("call writes", 2, wr_q.size())
    if (wr_q.size() == 2) begin
      `CHK("sub write", {8'h10, 8'(r + 8'd1)}, wr_q[0])
      `CHK("return write", {8'h11, 8'(r + 8'd1)}, wr_q[1])
    end
    // pushed byte went to the top of RAM, the last byte of endpoint 0
    usb_ep = 2'd0;
    usb_idx = 3'd7;
    repeat (2) @(negedge core_clk);
    `CHK("pushed byte", r, usb_rdata)
    summarize();
  end
endmodule
bind mcu8_core mcu8_core_chk u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .prog_addr(prog_addr), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
  .io_rd(io_rd), .halted(halted));
`default_nettype wire
